// ===== inc/uvf_map.svh
// Purpose: constants for the input undervoltage fault response sequencer
// Assumes: 25 MHz system clock
// Notes: register reached as a plain byte port, written by the host side
//
// What this block does
// - response 00: ignore the fault, output keeps running
// - response 01: keep running for delay count times delay unit
// - fault still present after that delay: act per retry field
// - response 10: disable output at once, then follow retry field
// - response 11: disable output and hold off until fault cleared
// - clear on status bit clear, clear-faults command or reset
// - clear on output commanded off then on, by pin or command
// - retry 000: no restart, output stays off until cleared
// - retry 001: one restart; failing that, stay off until cleared
// - restart attempts start spaced by delay count times delay unit, or by the restart window when that is longer
// - retry 010..110 gives 2..6 attempts; 111 retries without limit
// - delay field encodes two to the field value units, unit from 0xd2
`ifndef UVF_MAP_SVH
`define UVF_MAP_SVH
`define UVF_RESP_OFFSET 8'h5a
`define UVF_UNIT_OFFSET 8'hd2
`define UVF_RESP_RESET 8'h00
`define UVF_RSP_MSB 7
`define UVF_RSP_LSB 6
`define UVF_RTY_MSB 5
`define UVF_RTY_LSB 3
`define UVF_DLY_MSB 2
`define UVF_DLY_LSB 0
`define UVF_RTY_NONE 3'h0
`define UVF_RTY_FOREVER 3'h7
`define UVF_UNIT_RESET 16'h0001
`define UVF_START_NS 1000
`define UVF_CLK_NS 40
`define UVF_START_CYC ((`UVF_START_NS + `UVF_CLK_NS - 1) / `UVF_CLK_NS)
`endif

// ===== inc/uvf_pkg.sv
// Purpose: types for the undervoltage fault response sequencer
// Assumes: nothing
// Notes: state codes written out
`default_nettype none
package uvf_pkg;
   typedef enum logic [1:0] {
      UVF_IGNORE = 2'h0,
      UVF_DELAY_RUN = 2'h1,
      UVF_DISABLE_RETRY = 2'h2,
      UVF_LATCH_OFF = 2'h3
   } uvf_resp_t;
   typedef enum logic [2:0] {
      UVF_RUN = 3'h0,
      UVF_GRACE = 3'h1,
      UVF_WAIT = 3'h2,
      UVF_START = 3'h3,
      UVF_LATCHED = 3'h4
   } uvf_state_t;
endpackage : uvf_pkg
`default_nettype wire

// ===== hdl/uvf_delay_timer.sv
// Purpose: counts 2**code delay units, each unit a number of clock ticks
// Assumes: start and clear are one-cycle pulses
// Notes: unit tick comes from a divider so the long count stays narrow
`default_nettype none
module uvf_delay_timer #(
   parameter int UNIT_W = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // control
   input wire logic start,
   input wire logic clear,
   input wire logic [2:0] code,
   input wire logic [UNIT_W-1:0] unitTicks,
   // result
   output logic done,
   output logic busy
);
   logic [UNIT_W-1:0] divCnt;
   logic [7:0] unitsLeft;
   wire unitPulse = busy && (divCnt == '0);
   wire lastUnit = unitPulse && (unitsLeft == 8'h01);
   wire [UNIT_W-1:0] reloadDiv = (unitTicks == '0) ? '0 : unitTicks - 1'b1;

   // 2**code units
   function automatic logic [7:0] units_of(input logic [2:0] c);
      units_of = 8'h01 << c;
   endfunction : units_of

   always_ff @(posedge clk_sys) begin
      if (!resetn || clear) begin
         busy <= 1'b0;
         done <= 1'b0;
         divCnt <= '0;
         unitsLeft <= 8'h00;
      end else if (start) begin
         busy <= 1'b1;
         done <= 1'b0;
         divCnt <= reloadDiv;
         unitsLeft <= units_of(code);
      end else begin
         done <= lastUnit;
         if (lastUnit) begin
            busy <= 1'b0;
         end
         if (unitPulse) begin
            divCnt <= reloadDiv;
            unitsLeft <= unitsLeft - 8'h01;
         end else if (busy) begin
            divCnt <= divCnt - 1'b1;
         end
      end
   end
endmodule : uvf_delay_timer
`default_nettype wire

// ===== hdl/uvf_sequencer.sv
// Purpose: decides output enable after an input undervoltage fault
// Assumes: fault, clear and command inputs are synchronous to clk_sys
// Notes: a restart attempt fails if the fault is present at its end
`include "uvf_map.svh"
`default_nettype none
module uvf_sequencer
   import uvf_pkg::*;
#(
   parameter int UNIT_W = 16,
   parameter int START_CYC = `UVF_START_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register write port
   input wire logic regWrite,
   input wire logic [7:0] regWdata,
   input wire logic unitWrite,
   input wire logic [UNIT_W-1:0] unitWdata,
   // fault and clearing events
   input wire logic uvFault,
   input wire logic statusClear,
   input wire logic clearFaults,
   input wire logic outputCommandOn,
   // register readback and status
   output logic [7:0] input_undervoltage_fault_response,
   output logic [UNIT_W-1:0] delayUnit,
   output logic outputEnable,
   output logic faultLatched,
   output logic [2:0] attemptCount
);
   uvf_state_t state, next_state;
   logic cmdOnDly;
   logic nextEnable;
   logic nextLatched;
   logic tmrStart;
   logic tmrDone;
   logic tmrBusy;
   logic [15:0] startCnt;

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   wire uvf_resp_t respMode = uvf_resp_t'(
      input_undervoltage_fault_response[`UVF_RSP_MSB:`UVF_RSP_LSB]);
   wire [2:0] retryCode = input_undervoltage_fault_response[`UVF_RTY_MSB:`UVF_RTY_LSB];
   wire [2:0] delayCode = input_undervoltage_fault_response[`UVF_DLY_MSB:`UVF_DLY_LSB];
   // off then on edge of the combined pin/command enable
   wire cycleOn = outputCommandOn && !cmdOnDly;
   wire clearEvt = statusClear || clearFaults || cycleOn;
   wire commandedOff = !outputCommandOn;
   wire retryLeft = (retryCode == `UVF_RTY_FOREVER) || (attemptCount < retryCode);
   wire startDone = (state == UVF_START) && (startCnt == 16'h0000);
   // an expiry that fell inside a long restart window is not waited for again
   wire waitOver = (state == UVF_WAIT) && (tmrDone || !tmrBusy);
   wire attemptBegins = waitOver && !commandedOff;

   // ----------------------------------------
   // shared delay timer
   // ----------------------------------------
   uvf_delay_timer #(
      .UNIT_W(UNIT_W)
   ) u_timer (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .start(tmrStart),
      .clear(clearEvt),
      .code(delayCode),
      .unitTicks(delayUnit),
      .done(tmrDone),
      .busy(tmrBusy)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      tmrStart = 1'b0;
      case (state)
         UVF_RUN: begin
            if (uvFault) begin
               case (respMode)
                  UVF_IGNORE: next_state = UVF_RUN;
                  UVF_DELAY_RUN: begin
                     next_state = UVF_GRACE;
                     tmrStart = 1'b1;
                  end
                  UVF_DISABLE_RETRY: begin
                     if (retryCode == `UVF_RTY_NONE) begin
                        next_state = UVF_LATCHED;
                     end else begin
                        next_state = UVF_WAIT;
                        tmrStart = 1'b1;
                     end
                  end
                  default: next_state = UVF_LATCHED;
               endcase
            end
         end
         UVF_GRACE: begin
            if (tmrDone) begin
               if (!uvFault) begin
                  next_state = UVF_RUN;
               end else if (retryCode == `UVF_RTY_NONE) begin
                  next_state = UVF_LATCHED;
               end else begin
                  next_state = UVF_WAIT;
                  tmrStart = 1'b1;
               end
            end
         end
         UVF_WAIT: begin
            if (commandedOff) begin
               next_state = UVF_LATCHED;
            end else if (waitOver) begin
               next_state = UVF_START;
               tmrStart = 1'b1;
            end
         end
         UVF_START: begin
            if (commandedOff) begin
               next_state = UVF_LATCHED;
            end else if (startDone) begin
               if (!uvFault) begin
                  next_state = UVF_RUN;
               end else if (retryLeft) begin
                  next_state = UVF_WAIT;
               end else begin
                  next_state = UVF_LATCHED;
               end
            end
         end
         UVF_LATCHED: next_state = UVF_LATCHED;
         default: next_state = UVF_RUN;
      endcase
      if (clearEvt) begin
         next_state = UVF_RUN;
      end
   end

   // ----------------------------------------
   // output decode
   // ----------------------------------------
   // the converter runs in normal operation, in the grace delay and in a restart window
   function automatic logic runs_output(input uvf_state_t s);
      case (s)
         UVF_RUN: runs_output = 1'b1;
         UVF_GRACE: runs_output = 1'b1;
         UVF_START: runs_output = 1'b1;
         default: runs_output = 1'b0;
      endcase
   endfunction : runs_output

   assign nextEnable = runs_output(next_state);
   assign nextLatched = (next_state == UVF_LATCHED);

   // ----------------------------------------
   // state and status registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state <= UVF_RUN;
         outputEnable <= 1'b1;
         faultLatched <= 1'b0;
      end else begin
         state <= next_state;
         outputEnable <= nextEnable;
         faultLatched <= nextLatched;
      end
   end

   // ----------------------------------------
   // on-command edge memory
   // ----------------------------------------
   // resets high so a command already on at release is not taken as off then on
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cmdOnDly <= 1'b1;
      end else begin
         cmdOnDly <= outputCommandOn;
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         input_undervoltage_fault_response <= `UVF_RESP_RESET;
      end else if (regWrite) begin
         input_undervoltage_fault_response <= regWdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         delayUnit <= UNIT_W'(`UVF_UNIT_RESET);
      end else if (unitWrite) begin
         delayUnit <= unitWdata;
      end
   end

   // ----------------------------------------
   // restart attempts
   // ----------------------------------------
   // saturates at 7 so an endless retry never wraps back under a finite limit
   always_ff @(posedge clk_sys) begin
      if (!resetn || clearEvt) begin
         attemptCount <= 3'h0;
      end else if (next_state == UVF_RUN) begin
         attemptCount <= 3'h0;
      end else if (attemptBegins && (attemptCount != 3'h7)) begin
         attemptCount <= attemptCount + 3'h1;
      end
   end

   // restart window: the output is on for START_CYC cycles per attempt
   always_ff @(posedge clk_sys) begin
      if (!resetn || clearEvt) begin
         startCnt <= 16'h0000;
      end else if (attemptBegins) begin
         startCnt <= 16'(START_CYC - 1);
      end else if (startCnt != 16'h0000) begin
         startCnt <= startCnt - 16'h0001;
      end
   end
endmodule : uvf_sequencer
`default_nettype wire

// ===== sim/uvf_seq_sva.sv
// Purpose: port checks for the undervoltage fault sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: the immediate disable and latch-off checks skip cycles that carry a clear
`default_nettype none
module uvf_seq_chk #(
   parameter int UNIT_W = 16,
   parameter int START_CYC = 25
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // events
   input wire logic uvFault,
   input wire logic statusClear,
   input wire logic clearFaults,
   input wire logic outputCommandOn,
   // status
   input wire logic [7:0] input_undervoltage_fault_response,
   input wire logic outputEnable,
   input wire logic faultLatched,
   input wire logic [2:0] attemptCount
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rsp;
   logic lastOn;
   logic calm;
   assign rsp = input_undervoltage_fault_response;
   // a clear wins over a fault in the same cycle
   assign calm = !statusClear && !clearFaults && !(outputCommandOn && !lastOn);
   always_ff @(posedge clk_sys) begin
      lastOn <= outputCommandOn;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   chk_ignore_runs: assert property (rsp[7:6] == 2'h0 && outputEnable |=> outputEnable)
      else $error("output dropped on ignored fault");
   chk_grace_runs: assert property (rsp[7:6] == 2'h1 && $rose(uvFault) && outputEnable
      && rsp[2:0] != 3'h0 |=> outputEnable [*2]) else $error("grace cut short");
   chk_disable_now: assert property (rsp[7:6] == 2'h2 && uvFault && outputEnable
      && attemptCount == 3'h0 && calm |=> !outputEnable) else $error("output not cut");
   chk_latch_now: assert property (rsp[7:6] == 2'h3 && uvFault && calm
      |=> !outputEnable && faultLatched) else $error("latch off missed");
   chk_latched_off: assert property (faultLatched |-> !outputEnable)
      else $error("output on while latched");
   chk_clear_all: assert property (statusClear || clearFaults
      |=> !faultLatched && attemptCount == 3'h0) else $error("clear ignored");
   chk_cycle_on: assert property (outputCommandOn && !lastOn |=> !faultLatched)
      else $error("off then on did not clear");
   chk_attempt_limit: assert property (rsp[5:3] != 3'h7 |-> attemptCount <= rsp[5:3])
      else $error("too many restarts");
endmodule : uvf_seq_chk
`default_nettype wire

// ===== sim/uvf_host_model.sv
// Purpose: host and on/off pin model for the fault sequencer
// Assumes: tasks are entered 1 ns after a rising edge
// Notes: released data shows the inverse of the last value
`default_nettype none
module uvf_host_model (
   // clock
   input wire logic clk_sys,
   // register writes
   output logic regWrite,
   output logic [7:0] regWdata,
   output logic unitWrite,
   output logic [15:0] unitWdata,
   // clearing events
   output logic statusClear,
   output logic clearFaults,
   output logic outputCommandOn
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {regWrite, unitWrite, statusClear, clearFaults} = 4'h0;
      regWdata = 8'h00;
      unitWdata = 16'h0000;
      outputCommandOn = 1'b1;
   end
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step
   task automatic wr_resp(input logic [7:0] v);
      regWdata = v;
      regWrite = 1'b1;
      step();
      regWrite = 1'b0;
      regWdata = ~v;
      step();
   endtask : wr_resp
   task automatic wr_unit(input logic [15:0] v);
      unitWdata = v;
      unitWrite = 1'b1;
      step();
      unitWrite = 1'b0;
      unitWdata = ~v;
      step();
   endtask : wr_unit
   // one-cycle pulse: status bit clear (0) or clear-faults command (1)
   task automatic clear(input logic cmd);
      statusClear = !cmd;
      clearFaults = cmd;
      step();
      {statusClear, clearFaults} = 2'h0;
      step();
   endtask : clear
   task automatic turn(input logic on);
      outputCommandOn = on;
      step();
      step();
   endtask : turn
endmodule : uvf_host_model
`default_nettype wire

// ===== sim/test_uvf_sequencer.sv
// Purpose: self-checking bench for the undervoltage fault sequencer
// Assumes: host model drives writes and clears
// Notes: restart window cut to 4 cycles to keep runs short
`default_nettype none
module test_uvf_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic uvFault = 1'b0;
   logic regWrite, unitWrite, statusClear, clearFaults, outputCommandOn;
   logic outputEnable, faultLatched;
   logic [7:0] regWdata, rsp;
   logic [15:0] unitWdata, delayUnit;
   logic [2:0] attemptCount;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   always #20 clk_sys = ~clk_sys;
   uvf_host_model host (.clk_sys(clk_sys), .regWrite(regWrite), .regWdata(regWdata),
      .unitWrite(unitWrite), .unitWdata(unitWdata), .statusClear(statusClear),
      .clearFaults(clearFaults), .outputCommandOn(outputCommandOn));
   uvf_sequencer #(.START_CYC(4)) uut (.clk_sys(clk_sys), .resetn(resetn),
      .regWrite(regWrite), .regWdata(regWdata), .unitWrite(unitWrite),
      .unitWdata(unitWdata), .uvFault(uvFault), .statusClear(statusClear),
      .clearFaults(clearFaults), .outputCommandOn(outputCommandOn),
      .input_undervoltage_fault_response(rsp), .delayUnit(delayUnit),
      .outputEnable(outputEnable), .faultLatched(faultLatched),
      .attemptCount(attemptCount));
   task automatic end_sim();
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // packed as {on, latched, attempts}
   task automatic look(input logic [4:0] exp);
      chk("state", 16'(exp), 16'({outputEnable, faultLatched, attemptCount}));
   endtask : look
   task automatic wait_latch();
      n = 0;
      while (faultLatched !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
   endtask : wait_latch
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      tick(3);
      resetn = 1'b1;
      look(5'h10);
      chk("unit", 16'h0001, delayUnit);
      uvFault = 1'b1;
      tick(20);
      look(5'h10);
      uvFault = 1'b0;
      for (int r = 1; r < 7; r++) begin
         host.wr_resp({2'h2, 3'(r), 3'h2});
         uvFault = 1'b1;
         tick(1);
         look(5'h00);
         wait_latch();
         look({2'h1, 3'(r)});
         uvFault = 1'b0;
         host.clear(1'b1);
         look(5'h10);
      end
      host.wr_resp(8'hc0);
      uvFault = 1'b1;
      tick(1);
      uvFault = 1'b0;
      tick(10);
      look(5'h08);
      host.clear(1'b0);
      look(5'h10);
      host.wr_resp(8'h42);
      uvFault = 1'b1;
      n = 0;
      while (outputEnable === 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk("grace", 16'h0001, 16'(n >= 4 && n < 10));
      wait_latch();
      look(5'h08);
      uvFault = 1'b0;
      host.turn(1'b0);
      host.turn(1'b1);
      look(5'h10);
      host.wr_unit(16'h0003);
      chk("unit", 16'h0003, delayUnit);
      host.wr_resp(8'hb9);
      chk("resp", 16'h00b9, 16'(rsp));
      uvFault = 1'b1;
      tick(150);
      chk("latched", 16'h0000, 16'(faultLatched));
      host.turn(1'b0);
      chk("latched", 16'h0001, 16'(faultLatched));
      uvFault = 1'b0;
      host.turn(1'b1);
      look(5'h10);
      host.wr_resp(8'hc0);
      uvFault = 1'b1;
      tick(3);
      resetn = 1'b0;
      uvFault = 1'b0;
      tick(1);
      resetn = 1'b1;
      chk("resp", 16'h0000, 16'(rsp));
      look(5'h10);
      end_sim();
   end
endmodule : test_uvf_sequencer
bind uvf_sequencer uvf_seq_chk #(.UNIT_W(UNIT_W), .START_CYC(START_CYC)) chk_i (
   .clk_sys(clk_sys), .resetn(resetn), .uvFault(uvFault), .statusClear(statusClear),
   .clearFaults(clearFaults), .outputCommandOn(outputCommandOn),
   .input_undervoltage_fault_response(input_undervoltage_fault_response),
   .outputEnable(outputEnable), .faultLatched(faultLatched), .attemptCount(attemptCount));
`default_nettype wire
